/* verilog/video_display_command_handler.sv */
// Function
// - Format code 0 no field repeat, 3 PAL 50 Hz, 4 NTSC 60 Hz.
// - Second format argument is horizontal interpolation coefficient; zero disables it.
// - Third format argument zero gives progressive output, otherwise interlaced.
// - Vertical interpolation comes from a configuration location, not the command.
// - Zero left or top margin centres the window in that dimension.
// - Source column and row start pick the window's top-left picture pixel.
// - Zero width or height takes the size coded in the bitstream.
// - New window settings apply together after the next vertical blanking.
// - Horizontal values in 601 pixels, vertical values in SIF lines.
// - One-step decodes and shows one picture, then pauses, audio off.
// - Slow play holds each picture N frames, video only, no sync.
// - Speed is 1/N; host never sends N above 8.
// - Slow play takes input until a buffer fills, then end event.
// - Below threshold, input resumes and the refill event fires if enabled.
// - With a program ROM attached, start-up loads and runs unaided.
// - Event enable bit 13 covers end of pause, step or slow play; here only end of step and slow-play buffer full raise it.
// - Event enable bit 10 covers refill request during slow play.
// - Enabled events are recorded in status and raise the host pin.
//
// The Wishbone register port and the address map were left to the implementer.
module video_display_command_handler (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic vblank_i,
  input wire logic picture_done_i,
  input wire logic frame_tick_i,
  input wire logic buffer_full_i,
  input wire logic below_threshold_i,
  input wire logic rom_present_i,
  input wire logic rom_load_done_i,
  input wire logic [15:0] bs_width_i,
  input wire logic [15:0] bs_height_i,
  output logic host_int_o,
  output logic decode_en_o,
  output logic input_en_o,
  output logic audio_en_o,
  output logic show_picture_o,
  output logic av_sync_en_o,
  output logic cpu_run_o,
  output logic rom_load_o,
  output logic [1:0] rate_mode_o,
  output logic [15:0] horiz_interp_coeff_o,
  output logic horiz_interp_en_o,
  output logic interlaced_o,
  output logic [15:0] vert_interp_o,
  output vdc_pkg::window_t window_o
);

  typedef enum {ST_IDLE, ST_ARGS, ST_EXEC} cmd_state_t;
  typedef enum {PL_STOP, PL_STEP, PL_SLOW, PL_PAUSE} play_state_t;

  localparam logic [15:0] SCREEN_W = 16'h02d0;
  localparam logic [15:0] SCREEN_H = 16'h00f0;

  // ==========================================================================
  // Pin synchronisers.
  logic [5:0] pin_meta_reg;
  logic [5:0] pin_sync_reg;
  logic vblank_s, picture_s, frame_s, full_s, below_s, rom_done_s;
  logic vblank_prev_reg;
  logic picture_prev_reg;
  logic frame_prev_reg;
  logic vblank_rise, picture_rise, frame_rise;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      vblank_prev_reg <= 1'b0;
      picture_prev_reg <= 1'b0;
      frame_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg <= {rom_load_done_i, below_threshold_i, buffer_full_i,
                       frame_tick_i, picture_done_i, vblank_i};
      pin_sync_reg <= pin_meta_reg;
      vblank_prev_reg <= vblank_s;
      picture_prev_reg <= picture_s;
      frame_prev_reg <= frame_s;
    end
  end

  assign {rom_done_s, below_s, full_s, frame_s, picture_s, vblank_s} = pin_sync_reg;
  assign vblank_rise = vblank_s & ~vblank_prev_reg;
  assign picture_rise = picture_s & ~picture_prev_reg;
  assign frame_rise = frame_s & ~frame_prev_reg;

  // ==========================================================================
  // Wishbone slave, one wait state, ack one cycle after the strobe.
  logic bus_req;
  logic wr_stb;
  logic cmd_wr;
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_stb = bus_req & wb_we_i & (&wb_sel_i[1:0]);
  assign cmd_wr = wr_stb & (wb_adr_i == vdc_pkg::ADDR_CMD);

  // ==========================================================================
  // Command interpreter.
  cmd_state_t cmd_state_reg;
  logic [15:0] cmd_id_reg;
  logic [2:0] arg_need_reg;
  logic [2:0] arg_cnt_reg;
  logic [15:0] args_reg [0:5];
  logic cmd_busy;
  logic exec_pulse;
  logic unknown_cmd_reg;

  function automatic logic [2:0] arg_count(input logic [15:0] id);
    case (id)
      vdc_pkg::CMD_VIDEO_FORMAT: arg_count = vdc_pkg::ARGS_VIDEO_FORMAT;
      vdc_pkg::CMD_WINDOW_SETUP: arg_count = vdc_pkg::ARGS_WINDOW_SETUP;
      vdc_pkg::CMD_SLOW_PLAY: arg_count = vdc_pkg::ARGS_SLOW_PLAY;
      vdc_pkg::CMD_EVENT_ENABLE: arg_count = vdc_pkg::ARGS_EVENT_ENABLE;
      default: arg_count = 3'h0;
    endcase
  endfunction : arg_count

  assign cmd_busy = (cmd_state_reg != ST_IDLE) || (cmd_state_reg == ST_IDLE && 1'b0);
  assign exec_pulse = (cmd_state_reg == ST_EXEC);

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cmd_state_reg <= ST_IDLE;
      cmd_id_reg <= '0;
      arg_need_reg <= '0;
      arg_cnt_reg <= '0;
      unknown_cmd_reg <= 1'b0;
    end else begin
      case (cmd_state_reg)
        ST_IDLE: begin
          if (cmd_wr) begin
            cmd_id_reg <= wb_dat_i[15:0];
            arg_need_reg <= arg_count(wb_dat_i[15:0]);
            arg_cnt_reg <= '0;
            unknown_cmd_reg <= (wb_dat_i[15:0] != vdc_pkg::CMD_ONE_STEP) &&
                               (arg_count(wb_dat_i[15:0]) == 3'h0);
            cmd_state_reg <= (arg_count(wb_dat_i[15:0]) == 3'h0) ? ST_EXEC : ST_ARGS;
          end
        end
        ST_ARGS: begin
          if (cmd_wr) begin
            arg_cnt_reg <= arg_cnt_reg + 3'h1;
            if (arg_cnt_reg + 3'h1 == arg_need_reg) begin
              cmd_state_reg <= ST_EXEC;
            end
          end
        end
        ST_EXEC: cmd_state_reg <= ST_IDLE;
        default: cmd_state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (cmd_state_reg == ST_ARGS && cmd_wr) begin
      args_reg[arg_cnt_reg] <= wb_dat_i[15:0];
    end
  end

  // ==========================================================================
  // Video format settings.
  vdc_pkg::format_t fmt_reg;
  logic [15:0] vert_interp_reg;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      fmt_reg <= '0;
    end else if (exec_pulse && cmd_id_reg == vdc_pkg::CMD_VIDEO_FORMAT) begin
      fmt_reg.format_code <= args_reg[0];
      fmt_reg.horiz_interp_coeff <= args_reg[1];
      fmt_reg.interlaced <= (args_reg[2] != 16'h0000);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      vert_interp_reg <= '0;
    end else if (wr_stb && wb_adr_i == vdc_pkg::ADDR_VINTERP) begin
      vert_interp_reg <= wb_dat_i[15:0];
    end
  end

  // ==========================================================================
  // Window staging; 601 pixels across, SIF lines down.
  vdc_pkg::window_t win_pend_reg;
  logic win_pending_reg;
  logic win_load;
  vdc_pkg::window_t win_live;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      win_pend_reg <= '0;
      win_pending_reg <= 1'b0;
    end else if (exec_pulse && cmd_id_reg == vdc_pkg::CMD_WINDOW_SETUP) begin
      win_pend_reg <= {args_reg[0], args_reg[1], args_reg[2],
                       args_reg[3], args_reg[4], args_reg[5]};
      win_pending_reg <= 1'b1;
    end else if (win_load) begin
      win_pending_reg <= 1'b0;
    end
  end

  assign win_load = win_pending_reg & vblank_rise;

  win_resolve u_win_resolve (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .load_i(win_load),
    .win_i(win_pend_reg),
    .bs_width_i(bs_width_i),
    .bs_height_i(bs_height_i),
    .screen_width_i(SCREEN_W),
    .screen_height_i(SCREEN_H),
    .win_o(win_live)
  );

  // ==========================================================================
  // Playback control.
  play_state_t play_reg;
  logic [15:0] slow_n_reg;
  logic [15:0] hold_cnt_reg;
  logic input_en_reg;
  logic show_reg;
  logic end_evt;
  logic refill_evt;
  logic [15:0] n_clamped;

  // N limited to one to eight.
  assign n_clamped = (args_reg[0] > vdc_pkg::SLOW_MAX) ? vdc_pkg::SLOW_MAX :
                     (args_reg[0] < vdc_pkg::SLOW_MIN) ? vdc_pkg::SLOW_MIN : args_reg[0];

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      play_reg <= PL_STOP;
      slow_n_reg <= vdc_pkg::SLOW_MIN;
      hold_cnt_reg <= '0;
      show_reg <= 1'b0;
    end else begin
      show_reg <= 1'b0;
      if (exec_pulse && cmd_id_reg == vdc_pkg::CMD_ONE_STEP) begin
        play_reg <= PL_STEP;
      end else if (exec_pulse && cmd_id_reg == vdc_pkg::CMD_SLOW_PLAY) begin
        play_reg <= PL_SLOW;
        slow_n_reg <= n_clamped;
        hold_cnt_reg <= '0;
      end else begin
        case (play_reg)
          PL_STEP: begin
            if (picture_rise) begin
              show_reg <= 1'b1;
              play_reg <= PL_PAUSE;
            end
          end
          PL_SLOW: begin
            if (frame_rise) begin
              if (hold_cnt_reg == 16'h0000) begin
                show_reg <= 1'b1;
              end
              hold_cnt_reg <= (hold_cnt_reg + 16'h0001 >= slow_n_reg) ?
                              16'h0000 : hold_cnt_reg + 16'h0001;
            end
          end
          PL_PAUSE: play_reg <= PL_PAUSE;
          PL_STOP: play_reg <= PL_STOP;
          default: play_reg <= PL_STOP;
        endcase
      end
    end
  end

  // Stop input when full; resume below threshold.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      input_en_reg <= 1'b1;
    end else if (play_reg != PL_SLOW) begin
      input_en_reg <= 1'b1;
    end else if (input_en_reg && full_s) begin
      input_en_reg <= 1'b0;
    end else if (!input_en_reg && below_s) begin
      input_en_reg <= 1'b1;
    end
  end

  assign end_evt = (play_reg == PL_SLOW && input_en_reg && full_s) ||
                   (play_reg == PL_STEP && picture_rise);
  assign refill_evt = play_reg == PL_SLOW && !input_en_reg && below_s;

  // ==========================================================================
  // Event enables and status; status read clears, a new event wins.
  logic [15:0] mask_reg;
  logic [15:0] events_reg;
  logic [15:0] evt_now;
  logic evt_rd;
  logic int_reg;

  always_comb begin
    evt_now = '0;
    evt_now[vdc_pkg::EVT_END_PAUSE] = end_evt & mask_reg[vdc_pkg::EVT_END_PAUSE];
    evt_now[vdc_pkg::EVT_REFILL] = refill_evt & mask_reg[vdc_pkg::EVT_REFILL];
  end

  assign evt_rd = bus_req & ~wb_we_i & (wb_adr_i == vdc_pkg::ADDR_EVENTS);

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mask_reg <= '0;
    end else if (exec_pulse && cmd_id_reg == vdc_pkg::CMD_EVENT_ENABLE) begin
      mask_reg <= args_reg[0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      events_reg <= '0;
      int_reg <= 1'b0;
    end else begin
      events_reg <= (evt_rd ? 16'h0000 : events_reg) | evt_now;
      int_reg <= |((evt_rd ? 16'h0000 : events_reg) | evt_now);
    end
  end

  // ==========================================================================
  // Start-up: ROM load or host run enable.
  logic cpu_run_reg;
  logic rom_load_reg;
  logic boot_seen_reg;
  logic rom_meta_reg;
  logic rom_sync_reg;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rom_meta_reg <= 1'b0;
      rom_sync_reg <= 1'b0;
      cpu_run_reg <= 1'b0;
      rom_load_reg <= 1'b0;
      boot_seen_reg <= 1'b0;
    end else begin
      rom_meta_reg <= rom_present_i;
      rom_sync_reg <= rom_meta_reg;
      boot_seen_reg <= 1'b1;
      if (boot_seen_reg && !cpu_run_reg && rom_sync_reg && !rom_load_reg) begin
        rom_load_reg <= 1'b1;
      end else if (rom_load_reg && rom_done_s) begin
        rom_load_reg <= 1'b0;
        cpu_run_reg <= 1'b1;
      end else if (wr_stb && wb_adr_i == vdc_pkg::ADDR_CPU_RUN) begin
        cpu_run_reg <= wb_dat_i[0];
      end
    end
  end

  // ==========================================================================
  // Bus read mux and registered outputs.
  logic [31:0] rd_data;
  always_comb begin
    case (wb_adr_i)
      vdc_pkg::ADDR_STATUS: rd_data = {26'h0, unknown_cmd_reg, cpu_run_reg,
                                        win_pending_reg, input_en_reg, cmd_busy, 1'b0};
      vdc_pkg::ADDR_EVENTS: rd_data = {16'h0000, events_reg};
      vdc_pkg::ADDR_MASK: rd_data = {16'h0000, mask_reg};
      vdc_pkg::ADDR_FORMAT: rd_data = {15'h0, fmt_reg.interlaced,
                                        fmt_reg.format_code};
      vdc_pkg::ADDR_WIN_POS: rd_data = {win_live.top_margin_height,
                                         win_live.left_margin_width};
      vdc_pkg::ADDR_WIN_SRC: rd_data = {win_live.source_row_start,
                                         win_live.source_col_start};
      vdc_pkg::ADDR_WIN_SIZE: rd_data = {win_live.height, win_live.width};
      vdc_pkg::ADDR_VINTERP: rd_data = {16'h0000, vert_interp_reg};
      vdc_pkg::ADDR_CPU_RUN: rd_data = {31'h0, cpu_run_reg};
      default: rd_data = vdc_pkg::RESET_WORD;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= vdc_pkg::RESET_WORD;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_data : vdc_pkg::RESET_WORD;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      host_int_o <= 1'b0;
      decode_en_o <= 1'b0;
      input_en_o <= 1'b1;
      audio_en_o <= 1'b1;
      show_picture_o <= 1'b0;
      av_sync_en_o <= 1'b1;
      cpu_run_o <= 1'b0;
      rom_load_o <= 1'b0;
      rate_mode_o <= 2'h0;
      horiz_interp_coeff_o <= '0;
      horiz_interp_en_o <= 1'b0;
      interlaced_o <= 1'b0;
      vert_interp_o <= '0;
      window_o <= '0;
    end else begin
      host_int_o <= int_reg;
      decode_en_o <= (play_reg == PL_STEP) || (play_reg == PL_SLOW);
      input_en_o <= input_en_reg;
      audio_en_o <= (play_reg == PL_STOP);
      show_picture_o <= show_reg;
      av_sync_en_o <= (play_reg != PL_SLOW);
      cpu_run_o <= cpu_run_reg;
      rom_load_o <= rom_load_reg;
      rate_mode_o <= (fmt_reg.format_code == vdc_pkg::FMT_PAL) ? 2'h1 :
                     (fmt_reg.format_code == vdc_pkg::FMT_NTSC) ? 2'h2 : 2'h0;
      horiz_interp_coeff_o <= fmt_reg.horiz_interp_coeff;
      horiz_interp_en_o <= (fmt_reg.horiz_interp_coeff != 16'h0000);
      interlaced_o <= fmt_reg.interlaced;
      vert_interp_o <= vert_interp_reg;
      window_o <= win_live;
    end
  end

  // ==========================================================================
  // Checks.
  property p_ack_one;
    @(posedge core_clk_i) disable iff (!rst_n_i) bus_req |=> wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack missing");

  property p_int_follow;
    @(posedge core_clk_i) disable iff (!rst_n_i) |evt_now |=> ##1 host_int_o;
  endproperty
  a_int_follow: assert property (p_int_follow) else $error("int not raised");

  property p_win_hold;
    @(posedge core_clk_i) disable iff (!rst_n_i) !win_load |=> $stable(win_live);
  endproperty
  a_win_hold: assert property (p_win_hold) else $error("window changed early");

  property p_slow_nosync;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      play_reg == PL_SLOW ##1 play_reg == PL_SLOW |-> !av_sync_en_o;
  endproperty
  a_slow_nosync: assert property (p_slow_nosync) else $error("sync in slow play");

  property p_step_pause;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      play_reg == PL_STEP && picture_rise && !exec_pulse |=> play_reg == PL_PAUSE;
  endproperty
  a_step_pause: assert property (p_step_pause) else $error("step did not pause");

  property p_n_range;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      slow_n_reg <= vdc_pkg::SLOW_MAX && slow_n_reg >= vdc_pkg::SLOW_MIN;
  endproperty
  a_n_range: assert property (p_n_range) else $error("slow factor out of range");

  property p_full_stop;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      play_reg == PL_SLOW && full_s && !exec_pulse |=> ##1 !input_en_o;
  endproperty
  a_full_stop: assert property (p_full_stop) else $error("input not stopped");

  property p_interp_en;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      fmt_reg.horiz_interp_coeff == 16'h0000 |=> !horiz_interp_en_o;
  endproperty
  a_interp_en: assert property (p_interp_en) else $error("interp not disabled");

  c_slow: cover property (@(posedge core_clk_i) refill_evt);
  c_step: cover property (@(posedge core_clk_i) play_reg == PL_PAUSE);
  c_win: cover property (@(posedge core_clk_i) win_load);

endmodule : video_display_command_handler

/* verilog/vdc_pkg.sv */
package vdc_pkg;

  // ==========================================================================
  // Command identifiers and argument counts.
  localparam logic [15:0] CMD_VIDEO_FORMAT = 16'h0305;
  localparam logic [15:0] CMD_WINDOW_SETUP = 16'h0606;
  localparam logic [15:0] CMD_ONE_STEP = 16'h000b;
  localparam logic [15:0] CMD_SLOW_PLAY = 16'h0109;
  localparam logic [15:0] CMD_EVENT_ENABLE = 16'h0104;
  localparam logic [2:0] ARGS_VIDEO_FORMAT = 3'h3;
  localparam logic [2:0] ARGS_WINDOW_SETUP = 3'h6;
  localparam logic [2:0] ARGS_SLOW_PLAY = 3'h1;
  localparam logic [2:0] ARGS_EVENT_ENABLE = 3'h1;

  // ==========================================================================
  // Format codes and event bits.
  localparam logic [15:0] FMT_NO_REPEAT = 16'h0000;
  localparam logic [15:0] FMT_PAL = 16'h0003;
  localparam logic [15:0] FMT_NTSC = 16'h0004;
  localparam int EVT_END_PAUSE = 13;
  localparam int EVT_REFILL = 10;
  localparam logic [15:0] SLOW_MAX = 16'h0008;
  localparam logic [15:0] SLOW_MIN = 16'h0001;

  // ==========================================================================
  // Register map, byte addresses on the bus.
  localparam logic [5:0] ADDR_CMD = 6'h00;
  localparam logic [5:0] ADDR_STATUS = 6'h04;
  localparam logic [5:0] ADDR_EVENTS = 6'h08;
  localparam logic [5:0] ADDR_MASK = 6'h0c;
  localparam logic [5:0] ADDR_FORMAT = 6'h10;
  localparam logic [5:0] ADDR_WIN_POS = 6'h14;
  localparam logic [5:0] ADDR_WIN_SRC = 6'h18;
  localparam logic [5:0] ADDR_WIN_SIZE = 6'h1c;
  localparam logic [5:0] ADDR_VINTERP = 6'h20;
  localparam logic [5:0] ADDR_CPU_RUN = 6'h24;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // ==========================================================================
  // Grouped display settings.
  typedef struct packed {
    logic [15:0] left_margin_width;
    logic [15:0] top_margin_height;
    logic [15:0] source_col_start;
    logic [15:0] source_row_start;
    logic [15:0] width;
    logic [15:0] height;
  } window_t;

  typedef struct packed {
    logic [15:0] format_code;
    logic [15:0] horiz_interp_coeff;
    logic interlaced;
  } format_t;

endpackage : vdc_pkg

/* verilog/win_resolve.sv */
module win_resolve (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire vdc_pkg::window_t win_i,
  input wire logic [15:0] bs_width_i,
  input wire logic [15:0] bs_height_i,
  input wire logic [15:0] screen_width_i,
  input wire logic [15:0] screen_height_i,
  output vdc_pkg::window_t win_o
);

  // ==========================================================================
  // Zero-defaulted quantities are resolved at load time.
  function automatic logic [15:0] centre(input logic [15:0] screen, input logic [15:0] size);
    centre = (screen > size) ? 16'((screen - size) >> 1) : 16'h0000;
  endfunction : centre

  logic [15:0] w_eff;
  logic [15:0] h_eff;

  assign w_eff = (win_i.width == 16'h0000) ? bs_width_i : win_i.width;
  assign h_eff = (win_i.height == 16'h0000) ? bs_height_i : win_i.height;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      win_o <= '0;
    end else if (load_i) begin
      win_o.left_margin_width <= (win_i.left_margin_width == 16'h0000) ?
        centre(screen_width_i, w_eff) : win_i.left_margin_width;
      win_o.top_margin_height <= (win_i.top_margin_height == 16'h0000) ?
        centre(screen_height_i, h_eff) : win_i.top_margin_height;
      win_o.source_col_start <= win_i.source_col_start;
      win_o.source_row_start <= win_i.source_row_start;
      win_o.width <= w_eff;
      win_o.height <= h_eff;
    end
  end

endmodule : win_resolve

/* tb/host_model.sv */
// ======================================================
// Host side of the command bus.
module host_model (
  input wire logic clk_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_i,
  output logic [5:0] adr_o,
  output logic [31:0] dat_o,
  output logic [3:0] sel_o,
  output logic we_o,
  output logic cyc_o,
  output logic stb_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {adr_o, dat_o, sel_o, we_o, cyc_o, stb_o} = '0;
  // one transfer at a time, in order.
  task automatic xfer(input logic we, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    adr_o <= a;
    dat_o <= d;
    we_o <= we;
    sel_o <= 4'hf;
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    @(posedge clk_i);
    while (ack_i !== 1'b1) @(posedge clk_i);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // Released data is inverted so stale values never look valid.
    dat_o <= ~d;
    @(posedge clk_i);
  endtask : xfer
endmodule : host_model

/* tb/test_video_display_command_handler.sv */
module test_video_display_command_handler;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i, rst_n_i, vb, pd, ft, bf, bt, rp, rl, we, cyc, stb, ack, hi, de, ie, ae;
  logic sp, av, cr, ro, hen, il;
  logic [1:0] rm;
  logic [3:0] sel;
  logic [5:0] adr;
  logic [15:0] hc, vi;
  logic [31:0] dw, dr, q;
  vdc_pkg::window_t win;
  int failures, tests_run;
  logic [15:0] rows [3][4] = '{'{16'h0000, 16'h0000, 16'h0000, 16'h0000},
    '{16'h0003, 16'h0005, 16'h0001, 16'h0001}, '{16'h0004, 16'h0007, 16'h0009, 16'h0002}};
  logic [15:0] wa [6] = '{16'h0010, 16'h0000, 16'h0004, 16'h0002, 16'h0000, 16'h0064};
  video_display_command_handler video_display_command_handler_i (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .wb_adr_i(adr), .wb_dat_i(dw), .wb_sel_i(sel), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dr), .wb_ack_o(ack), .vblank_i(vb),
    .picture_done_i(pd), .frame_tick_i(ft), .buffer_full_i(bf), .below_threshold_i(bt),
    .rom_present_i(rp), .rom_load_done_i(rl), .bs_width_i(16'h0160), .bs_height_i(16'h00f0),
    .host_int_o(hi), .decode_en_o(de), .input_en_o(ie), .audio_en_o(ae),
    .show_picture_o(sp), .av_sync_en_o(av), .cpu_run_o(cr), .rom_load_o(ro), .rate_mode_o(rm),
    .horiz_interp_coeff_o(hc), .horiz_interp_en_o(hen), .interlaced_o(il),
    .vert_interp_o(vi), .window_o(win));
  host_model host_model_i (.clk_i(core_clk_i), .dat_i(dr), .ack_i(ack), .adr_o(adr),
    .dat_o(dw), .sel_o(sel), .we_o(we), .cyc_o(cyc), .stb_o(stb));
  task automatic chk(input string n, input logic [95:0] e, input logic [95:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    host_model_i.xfer(1'b1, a, {16'h0000, d}, q);
  endtask : wr
  task automatic rd(input logic [5:0] a);
    host_model_i.xfer(1'b0, a, 32'h0000_0000, q);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : idle
  task automatic summarize;
    $display("tests_run %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  initial begin
    #300000;
    failures++;
    summarize();
  end
  // ======================================================
  // Main sequence.
  initial begin
    {rst_n_i, vb, pd, ft, bf, bt, rp, rl} = '0;
    failures = 0;
    tests_run = 0;
    idle(6);
    rst_n_i <= 1'b1;
    idle(1);
    chk("reset_out", 4'b0111, {hi, ie, ae, av});
    rd(6'h3c);
    chk("unmapped", 0, q);
    wr(vdc_pkg::ADDR_VINTERP, 16'h0055);
    $display("reset test done");
    for (int i = 0; i < 3; i++) begin
      wr(vdc_pkg::ADDR_CMD, vdc_pkg::CMD_VIDEO_FORMAT);
      for (int k = 0; k < 3; k++) wr(vdc_pkg::ADDR_CMD, rows[i][k]);
      idle(2);
      chk("format", {rows[i][3][1:0], rows[i][1] != 0, rows[i][2] != 0, rows[i][1]},
          {rm, hen, il, hc});
    end
    chk("vinterp", 16'h0055, vi);
    $display("format test done");
    wr(vdc_pkg::ADDR_CMD, vdc_pkg::CMD_WINDOW_SETUP);
    for (int k = 0; k < 6; k++) wr(vdc_pkg::ADDR_CMD, wa[k]);
    idle(4);
    chk("win_hold", 0, win);
    vb <= 1'b1;
    idle(2);
    vb <= 1'b0;
    idle(8);
    chk("win", {wa[0], 16'h0046, wa[2], wa[3], 16'h0160, wa[5]}, win);
    $display("window test done");
    wr(vdc_pkg::ADDR_CMD, vdc_pkg::CMD_EVENT_ENABLE);
    wr(vdc_pkg::ADDR_CMD, 16'h2400);
    wr(vdc_pkg::ADDR_CMD, vdc_pkg::CMD_ONE_STEP);
    idle(2);
    chk("step_en", 2'b10, {de, ae});
    pd <= 1'b1;
    idle(2);
    pd <= 1'b0;
    idle(8);
    chk("step_int", 1, hi);
    rd(vdc_pkg::ADDR_EVENTS);
    chk("step_evt", 32'h0000_2000, q);
    idle(2);
    chk("int_clr", 0, hi);
    wr(vdc_pkg::ADDR_CMD, vdc_pkg::CMD_SLOW_PLAY);
    wr(vdc_pkg::ADDR_CMD, 16'h0008);
    idle(2);
    chk("slow_en", 2'b10, {de, av});
    ft <= 1'b1;
    idle(5);
    chk("slow_show", 1, sp);
    ft <= 1'b0;
    idle(3);
    ft <= 1'b1;
    idle(5);
    chk("slow_hold", 0, sp);
    ft <= 1'b0;
    bf <= 1'b1;
    idle(8);
    chk("slow_full", 2'b01, {ie, hi});
    bf <= 1'b0;
    bt <= 1'b1;
    idle(8);
    chk("slow_refill", 1, ie);
    rd(vdc_pkg::ADDR_EVENTS);
    chk("slow_evt", 32'h0000_2400, q);
    wr(vdc_pkg::ADDR_CPU_RUN, 16'h0001);
    idle(2);
    chk("cpu_run", 1, cr);
    $display("play test done");
    rst_n_i <= 1'b0;
    rp <= 1'b1;
    idle(6);
    rst_n_i <= 1'b1;
    idle(6);
    chk("rom_load", 3'b100, {ro, cr, hi});
    rl <= 1'b1;
    idle(6);
    chk("rom_boot", 2'b01, {ro, cr});
    $display("boot test done");
    summarize();
  end
endmodule : test_video_display_command_handler
